// *** hdl/pmc_pkg.sv ***
// Shared constants and types of the power mode control block
package pmc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] PMC_IDX = 8'h87;
  localparam logic [7:0] SLEEP_IDX = 8'hbe;
  localparam logic [7:0] IRQ_STAT_IDX = 8'hc0;
  localparam logic [7:0] IRQ_MASK_IDX = 8'hc1;
  localparam logic [11:0] PMC_ADDR = {2'h0, PMC_IDX, 2'h0};
  localparam logic [11:0] SLEEP_ADDR = {2'h0, SLEEP_IDX, 2'h0};
  localparam logic [11:0] IRQ_STAT_ADDR = {2'h0, IRQ_STAT_IDX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};
  // power_mode_control fields
  localparam int unsigned PMC_IDLE_BIT = 0;
  localparam int unsigned PMC_RSVD_BIT = 1;
  localparam int unsigned PMC_SPARE_LSB = 2;
  localparam logic [5:0] PMC_SPARE_RST = 6'h00;
  // sleep_and_oscillator_status fields
  localparam int unsigned SLP_SBUS_EN_BIT = 7;
  localparam int unsigned SLP_CRYSTAL_OSC_STABLE_BIT = 6;
  localparam int unsigned SLP_FAST_RC_OSC_STABLE_BIT = 5;
  localparam int unsigned SLP_RST_LSB = 3;
  localparam int unsigned SLP_PD_BIT = 2;
  localparam int unsigned SLP_MODE_LSB = 0;
  localparam logic SLP_SBUS_EN_RST = 1'b0;
  localparam logic SLP_PD_RST = 1'b1;
  localparam logic [1:0] SLP_MODE_RST = 2'h0;
  localparam logic [1:0] RST_CAUSE_RST = 2'h0;
  localparam logic [1:0] CAUSE_POWER_ON = 2'h0;
  localparam logic [1:0] CAUSE_PIN = 2'h1;
  localparam logic [1:0] CAUSE_WATCHDOG = 2'h2;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_ONE = 2'h1;
  localparam logic [1:0] MODE_TWO = 2'h2;
  localparam logic [1:0] MODE_THREE = 2'h3;
  localparam logic SEL_XOSC = 1'b0;
  // Interrupt status bits
  localparam int unsigned IRQ_N = 4;
  localparam int unsigned IRQ_WAKE = 0;
  localparam int unsigned IRQ_XOSC_UP = 1;
  localparam int unsigned IRQ_HFRC_UP = 2;
  localparam int unsigned IRQ_PD_DONE = 3;
  localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [4:0] {
    PM_ACTIVE = 5'h01,
    PM_IDLE = 5'h02,
    PM_LEVEL_ONE = 5'h04,
    PM_LEVEL_TWO = 5'h08,
    PM_LEVEL_THREE = 5'h10
  } pmc_state_type;
endpackage

// *** hdl/pmc_bus_if.sv ***
// Internal register access request between bus slave and core
`timescale 1ns/1ps
`default_nettype none
interface pmc_bus_if;
  logic req;
  logic write;
  logic [11:0] addr;
  logic [31:0] wdata;
  modport slave (output req, output write, output addr, output wdata);
  modport core (input req, input write, input addr, input wdata);
endinterface
`default_nettype wire

// *** hdl/pmc_ahb_slave.sv ***
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ps
`default_nettype none
module pmc_ahb_slave
  import pmc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic [11:0] i_haddr,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  pmc_bus_if.slave bus
);
  logic pend;
  logic pend_wr;
  logic [11:0] pend_addr;
  wire take = i_hsel & i_htrans[1] & i_hready;

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pend <= 1'b0;
      pend_wr <= 1'b0;
      pend_addr <= 12'h000;
      o_hreadyout <= 1'b1;
    end
    else if (i_clk_en)
    begin
      pend <= take;
      o_hreadyout <= ~take;
      if (take)
      begin
        pend_wr <= i_hwrite;
        pend_addr <= i_haddr;
      end
    end
  end

  // Request stands in the first data phase cycle, with hwdata valid
  assign bus.req = pend;
  assign bus.write = pend_wr;
  assign bus.addr = pend_addr;
  assign bus.wdata = i_hwdata;
endmodule
`default_nettype wire

// *** hdl/pmc_irq_status.sv ***
// Sticky interrupt status bits with mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module pmc_irq_status
  import pmc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [IRQ_N-1:0] i_event,
  input wire logic i_clear,
  input wire logic [IRQ_N-1:0] i_mask,
  output logic [IRQ_N-1:0] o_status,
  output logic o_irq
);
  for (genvar g = 0; g < IRQ_N; g++)
  begin : g_bit
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
      if (i_sys_rst)
        o_status[g] <= 1'b0;
      else if (i_clk_en)
      begin
        // Set wins over read clear
        if (i_event[g])
          o_status[g] <= 1'b1;
        else if (i_clear)
          o_status[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else if (i_clk_en)
      o_irq <= |(o_status & i_mask);
  end
endmodule
`default_nettype wire

// *** hdl/pmc_power_mode_ctrl.sv ***
// Power mode control and sleep/oscillator status registers on AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_ctrl
  import pmc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_irq_req,
  input wire logic i_port_irq,
  input wire logic i_sleep_timer_irq,
  input wire logic i_xosc_stable,
  input wire logic i_hfrc_stable,
  input wire logic i_clk_src_sel,
  input wire logic i_cal_busy,
  input wire logic [1:0] i_reset_cause,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  output logic o_irq,
  output logic o_cpu_halt,
  output logic o_deep_sleep,
  output logic o_regulator_off,
  output logic o_slow_osc_off,
  output logic o_xosc_pd,
  output logic o_hfrc_pd,
  output logic o_serial_bus_en,
  output logic o_serial_bus_rst
);
  pmc_bus_if bus ();
  pmc_state_type state;
  pmc_state_type next_state;
  logic [5:0] pmc_spare;
  logic cpu_stuck;
  logic sbus_en;
  logic unselected_osc_powerdown;
  logic pd_pending;
  logic next_unselected_osc_powerdown;
  logic next_pd_pending;
  logic [1:0] sleep_mode;
  logic [1:0] rst_cause;
  logic armed;
  logic sel_q;
  logic xosc_q;
  logic hfrc_q;
  logic xstb_prev;
  logic hstb_prev;
  logic [IRQ_N-1:0] irq_mask;
  logic [IRQ_N-1:0] irq_stat;
  logic [IRQ_N-1:0] irq_event;
  logic [31:0] pmc_rd;
  logic [31:0] sleep_rd;
  logic [31:0] rd_data;

  pmc_ahb_slave u_slave (
    .i_mclk (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en (i_clk_en),
    .i_hsel (i_hsel),
    .i_htrans (i_htrans),
    .i_haddr (i_haddr[11:0]),
    .i_hwrite (i_hwrite),
    .i_hwdata (i_hwdata),
    .i_hready (i_hready),
    .o_hreadyout (o_hreadyout),
    .bus (bus)
  );

  // Address decode
  wire acc_pmc = bus.req & (bus.addr == PMC_ADDR);
  wire acc_sleep = bus.req & (bus.addr == SLEEP_ADDR);
  wire acc_stat = bus.req & (bus.addr == IRQ_STAT_ADDR);
  wire acc_mask = bus.req & (bus.addr == IRQ_MASK_ADDR);
  wire wr_pmc = acc_pmc & bus.write;
  wire wr_sleep = acc_sleep & bus.write;
  wire wr_mask = acc_mask & bus.write;
  wire rd_any = bus.req & ~bus.write;
  wire rd_stat = acc_stat & ~bus.write;

  wire idle_go = wr_pmc & bus.wdata[PMC_IDLE_BIT];
  wire halt_go = wr_pmc & bus.wdata[PMC_RSVD_BIT];
  wire wake_timer = i_port_irq | i_sleep_timer_irq;
  wire wake_irq = i_irq_req | wake_timer;
  wire pd_wr_val = bus.wdata[SLP_PD_BIT];
  wire sel_toggle = armed & (i_clk_src_sel != sel_q);

  pmc_irq_status u_irq (
    .i_mclk (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en (i_clk_en),
    .i_event (irq_event),
    .i_clear (rd_stat),
    .i_mask (irq_mask),
    .o_status (irq_stat),
    .o_irq (o_irq)
  );

  // Power mode sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      PM_ACTIVE:
      begin
        // A simultaneous interrupt cancels the trigger
        if (idle_go && !wake_irq)
        begin
          unique case (sleep_mode)
            MODE_IDLE: next_state = PM_IDLE;
            MODE_ONE: next_state = PM_LEVEL_ONE;
            MODE_TWO: next_state = PM_LEVEL_TWO;
            MODE_THREE: next_state = PM_LEVEL_THREE;
          endcase
        end
      end
      PM_IDLE:
      begin
        if (wake_irq)
          next_state = PM_ACTIVE;
      end
      PM_LEVEL_ONE, PM_LEVEL_TWO:
      begin
        if (wake_timer)
          next_state = PM_ACTIVE;
      end
      PM_LEVEL_THREE:
      begin
        // Sleep timer is stopped in the deepest level
        if (i_port_irq)
          next_state = PM_ACTIVE;
      end
      default: next_state = PM_ACTIVE;
    endcase
  end

  wire next_deep = (next_state == PM_LEVEL_ONE) |
    (next_state == PM_LEVEL_TWO) | (next_state == PM_LEVEL_THREE);
  wire next_no_reg = (next_state == PM_LEVEL_TWO) |
    (next_state == PM_LEVEL_THREE);
  wire deep_entry = (state == PM_ACTIVE) & next_deep;
  wire deep_wake = ((state == PM_LEVEL_TWO) | (state == PM_LEVEL_THREE)) &
    (next_state == PM_ACTIVE);
  wire any_wake = (state != PM_ACTIVE) & (next_state == PM_ACTIVE);

  // Power-on reset also returns the device to active
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state <= PM_ACTIVE;
    else if (i_clk_en)
      state <= next_state;
  end

  // Deferred oscillator power-down
  always_comb
  begin
    next_unselected_osc_powerdown = unselected_osc_powerdown;
    next_pd_pending = pd_pending;
    if (sel_toggle)
    begin
      next_unselected_osc_powerdown = 1'b0;
      next_pd_pending = 1'b0;
    end
    else if (wr_sleep && pd_wr_val && i_cal_busy)
      next_pd_pending = 1'b1;
    else if (wr_sleep)
    begin
      next_unselected_osc_powerdown = pd_wr_val;
      next_pd_pending = 1'b0;
    end
    else if (pd_pending && !i_cal_busy)
    begin
      next_unselected_osc_powerdown = 1'b1;
      next_pd_pending = 1'b0;
    end
  end

  wire pd_done = pd_pending & ~next_pd_pending & next_unselected_osc_powerdown;
  // Calibration keeps both oscillators running outside the deep levels
  wire pd_allowed = unselected_osc_powerdown & ~i_cal_busy;
  wire next_xosc_pd = next_deep | (pd_allowed & (sel_q != SEL_XOSC));
  wire next_hfrc_pd = next_deep | (pd_allowed & (sel_q == SEL_XOSC));

  // Nothing below is touched by sleep entry except named fields
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pmc_spare <= PMC_SPARE_RST;
      cpu_stuck <= 1'b0;
      sbus_en <= SLP_SBUS_EN_RST;
      unselected_osc_powerdown <= SLP_PD_RST;
      pd_pending <= 1'b0;
      sleep_mode <= SLP_MODE_RST;
      irq_mask <= IRQ_MASK_RST;
    end
    else if (i_clk_en)
    begin
      if (wr_pmc)
        pmc_spare <= bus.wdata[PMC_SPARE_LSB +: 6];
      if (halt_go)
        cpu_stuck <= 1'b1;
      if (deep_wake)
        sbus_en <= 1'b0;
      else if (wr_sleep)
        sbus_en <= bus.wdata[SLP_SBUS_EN_BIT];
      unselected_osc_powerdown <= next_unselected_osc_powerdown;
      pd_pending <= next_pd_pending;
      if (deep_entry)
        sleep_mode <= MODE_IDLE;
      else if (wr_sleep)
        sleep_mode <= bus.wdata[SLP_MODE_LSB +: 2];
      if (wr_mask)
        irq_mask <= bus.wdata[IRQ_N-1:0];
    end
  end

  // Reset cause is caught at the first edge after release; clock select is sampled every edge
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      armed <= 1'b0;
      rst_cause <= RST_CAUSE_RST;
      sel_q <= SEL_XOSC;
    end
    else if (i_clk_en)
    begin
      sel_q <= i_clk_src_sel;
      if (!armed)
      begin
        armed <= 1'b1;
        rst_cause <= i_reset_cause;
      end
    end
  end

  wire xstb_rd = xosc_q & ~o_xosc_pd;
  wire hstb_rd = hfrc_q & ~o_hfrc_pd;

  // Oscillator status sampling
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      xosc_q <= 1'b0;
      hfrc_q <= 1'b0;
      xstb_prev <= 1'b0;
      hstb_prev <= 1'b0;
    end
    else if (i_clk_en)
    begin
      xosc_q <= i_xosc_stable;
      hfrc_q <= i_hfrc_stable;
      xstb_prev <= xstb_rd;
      hstb_prev <= hstb_rd;
    end
  end

  assign irq_event[IRQ_WAKE] = any_wake;
  assign irq_event[IRQ_XOSC_UP] = xstb_rd & ~xstb_prev;
  assign irq_event[IRQ_HFRC_UP] = hstb_rd & ~hstb_prev;
  assign irq_event[IRQ_PD_DONE] = pd_done;

  // Read data; trigger and reserved bits never read back
  assign pmc_rd = {24'h000000, pmc_spare, 2'h0};
  assign sleep_rd = {24'h000000, sbus_en, xstb_rd, hstb_rd, rst_cause,
    unselected_osc_powerdown, sleep_mode};
  assign rd_data = acc_pmc ? pmc_rd :
    acc_sleep ? sleep_rd :
    acc_stat ? {{(32-IRQ_N){1'b0}}, irq_stat} :
    acc_mask ? {{(32-IRQ_N){1'b0}}, irq_mask} :
    32'h00000000;

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_hrdata <= 32'h00000000;
      o_hresp <= HRESP_OKAY;
    end
    else if (i_clk_en)
    begin
      o_hresp <= HRESP_OKAY;
      if (rd_any)
        o_hrdata <= rd_data;
    end
  end

  // Power and clock control outputs
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_cpu_halt <= 1'b0;
      o_deep_sleep <= 1'b0;
      o_regulator_off <= 1'b0;
      o_slow_osc_off <= 1'b0;
      o_xosc_pd <= 1'b0;
      o_hfrc_pd <= 1'b0;
      o_serial_bus_en <= SLP_SBUS_EN_RST;
      o_serial_bus_rst <= 1'b1;
    end
    else if (i_clk_en)
    begin
      o_cpu_halt <= (next_state != PM_ACTIVE) | cpu_stuck | halt_go;
      o_deep_sleep <= next_deep;
      o_regulator_off <= next_no_reg;
      o_slow_osc_off <= (next_state == PM_LEVEL_THREE);
      o_xosc_pd <= next_xosc_pd;
      o_hfrc_pd <= next_hfrc_pd;
      o_serial_bus_en <= sbus_en;
      o_serial_bus_rst <= ~sbus_en;
    end
  end
endmodule
`default_nettype wire

// *** sim/pmc_power_mode_ctrl_properties.sv ***
// Port-level checks of the power mode control block
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_ctrl_properties
  import pmc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_port_irq,
  input wire logic i_sleep_timer_irq,
  input wire logic i_cal_busy,
  input wire logic o_cpu_halt,
  input wire logic o_deep_sleep,
  input wire logic o_regulator_off,
  input wire logic o_slow_osc_off,
  input wire logic o_xosc_pd,
  input wire logic o_hfrc_pd,
  input wire logic o_serial_bus_en,
  input wire logic o_serial_bus_rst
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  a_sbus_rst_inv: assert property (
    o_serial_bus_rst == !o_serial_bus_en)
    else $error("serial bus reset not inverse of enable");
  a_halt_in_deep: assert property (
    o_deep_sleep |-> o_cpu_halt)
    else $error("core running in deep level");
  a_level_nesting: assert property (
    o_slow_osc_off |-> o_regulator_off && o_deep_sleep)
    else $error("level three outputs inconsistent");
  a_port_wake: assert property (
    o_deep_sleep && i_port_irq && i_clk_en |=> !o_deep_sleep)
    else $error("port interrupt did not wake");
  a_timer_wake: assert property (
    o_deep_sleep && !o_slow_osc_off && i_sleep_timer_irq && i_clk_en
    |=> !o_deep_sleep)
    else $error("timer did not wake levels one or two");
  a_timer_level3: assert property (
    o_slow_osc_off && i_sleep_timer_irq && !i_port_irq |=> o_slow_osc_off)
    else $error("timer woke level three");
  a_osc_off_deep: assert property (
    o_deep_sleep |-> o_xosc_pd && o_hfrc_pd)
    else $error("fast oscillator powered in deep level");
  a_cal_defers: assert property (
    i_cal_busy && i_clk_en && !o_deep_sleep |=> !o_xosc_pd && !o_hfrc_pd)
    else $error("oscillator powered down during calibration");
  a_ready_wait: assert property (
    i_hsel && i_htrans[1] && i_hready && i_clk_en
    |=> !o_hreadyout ##1 o_hreadyout)
    else $error("transfer wait state not exactly one cycle");
  a_resp_okay: assert property (
    o_hresp == HRESP_OKAY)
    else $error("slave response not okay");
  c_level_three: cover property (o_slow_osc_off);
  c_idle_only: cover property (o_cpu_halt && !o_deep_sleep);
  c_cal_hold: cover property (i_cal_busy && !o_xosc_pd);
endmodule
bind pmc_power_mode_ctrl pmc_power_mode_ctrl_properties u_props (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
  .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .i_port_irq(i_port_irq), .i_sleep_timer_irq(i_sleep_timer_irq),
  .i_cal_busy(i_cal_busy), .o_cpu_halt(o_cpu_halt),
  .o_deep_sleep(o_deep_sleep), .o_regulator_off(o_regulator_off),
  .o_slow_osc_off(o_slow_osc_off), .o_xosc_pd(o_xosc_pd),
  .o_hfrc_pd(o_hfrc_pd), .o_serial_bus_en(o_serial_bus_en),
  .o_serial_bus_rst(o_serial_bus_rst)
);
`default_nettype wire

// *** sim/pmc_power_mode_ctrl_tb.sv ***
// Self-checking bench of the power mode control block
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_ctrl_tb
  import pmc_pkg::*;
;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b1, i_hsel = 1'b0;
  logic i_hwrite = 1'b0, i_irq_req = 1'b0, i_port_irq = 1'b0;
  logic i_sleep_timer_irq = 1'b0, i_xosc_stable = 1'b1, i_hfrc_stable = 1'b1;
  logic i_clk_src_sel = 1'b0, i_cal_busy = 1'b0;
  logic [1:0] i_htrans = 2'h0, i_reset_cause = 2'h1;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, rd;
  logic o_hreadyout, o_hresp, o_irq, o_cpu_halt, o_deep_sleep;
  logic o_regulator_off, o_slow_osc_off, o_xosc_pd, o_hfrc_pd;
  logic o_serial_bus_en, o_serial_bus_rst;
  int failures = 0, cmp_count = 0;
  typedef struct packed {logic [11:0] a; logic wr; logic [31:0] wd, exp;}
    pmc_row_type;
  pmc_row_type rows [6] = '{
    '{PMC_ADDR, 1'b0, 32'h0, 32'h0},
    '{SLEEP_ADDR, 1'b0, 32'h0, 32'h4c},
    '{PMC_ADDR, 1'b1, 32'ha8, 32'ha8},
    '{SLEEP_ADDR, 1'b1, 32'h80, 32'he8},
    '{IRQ_MASK_ADDR, 1'b1, 32'hf, 32'hf},
    '{12'h100, 1'b1, 32'hff, 32'h0}};
  pmc_power_mode_ctrl uut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .i_irq_req(i_irq_req), .i_port_irq(i_port_irq),
    .i_sleep_timer_irq(i_sleep_timer_irq), .i_xosc_stable(i_xosc_stable),
    .i_hfrc_stable(i_hfrc_stable), .i_clk_src_sel(i_clk_src_sel),
    .i_cal_busy(i_cal_busy), .i_reset_cause(i_reset_cause),
    .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp),
    .o_irq(o_irq), .o_cpu_halt(o_cpu_halt), .o_deep_sleep(o_deep_sleep),
    .o_regulator_off(o_regulator_off), .o_slow_osc_off(o_slow_osc_off),
    .o_xosc_pd(o_xosc_pd), .o_hfrc_pd(o_hfrc_pd),
    .o_serial_bus_en(o_serial_bus_en), .o_serial_bus_rst(o_serial_bus_rst));
  always #2.5 i_mclk = ~i_mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {20'h0, a};
    i_hwrite <= wr;
    @(posedge i_mclk);
    while (o_hreadyout !== 1'b1) @(posedge i_mclk);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    @(posedge i_mclk);
    while (o_hreadyout !== 1'b1) @(posedge i_mclk);
    rd = o_hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    close_out();
  end
  initial
  begin
    tick(3);
    chk(o_serial_bus_rst, 1);
    chk(o_serial_bus_en, 0);
    chk(o_hreadyout, 1);
    i_sys_rst <= 1'b0;
    foreach (rows[k])
    begin
      if (rows[k].wr)
        xfer(1'b1, rows[k].a, rows[k].wd);
      xfer(1'b0, rows[k].a, 32'h0);
      chk(rd, rows[k].exp);
      chk(o_hresp, HRESP_OKAY);
    end
    chk(o_serial_bus_en, 1);
    // Clear whatever start-up events are pending
    xfer(1'b0, IRQ_STAT_ADDR, 32'h0);
    xfer(1'b0, IRQ_STAT_ADDR, 32'h0);
    chk(rd, 0);
    tick(3);
    chk(o_irq, 0);
    i_hfrc_stable <= 1'b0;
    tick(3);
    i_hfrc_stable <= 1'b1;
    tick(4);
    chk(o_irq, 1);
    xfer(1'b0, IRQ_STAT_ADDR, 32'h0);
    chk(rd, 32'h4);
    tick(3);
    chk(o_irq, 0);
    xfer(1'b1, PMC_ADDR, 32'h1);
    tick(2);
    chk(o_cpu_halt, 1);
    chk(o_deep_sleep, 0);
    xfer(1'b0, PMC_ADDR, 32'h0);
    chk(rd, 0);
    i_irq_req <= 1'b1;
    tick(1);
    i_irq_req <= 1'b0;
    tick(3);
    chk(o_cpu_halt, 0);
    for (int m = 1; m < 4; m++)
    begin
      xfer(1'b1, SLEEP_ADDR, 32'h80 | m);
      xfer(1'b1, PMC_ADDR, 32'h1);
      tick(2);
      chk(o_deep_sleep, 1);
      chk(o_regulator_off, m > 1);
      chk(o_slow_osc_off, m == 3);
      xfer(1'b0, SLEEP_ADDR, 32'h0);
      chk(rd & 32'h87, 32'h80);
      i_sleep_timer_irq <= 1'b1;
      tick(3);
      chk(o_deep_sleep, m == 3);
      i_sleep_timer_irq <= 1'b0;
      i_port_irq <= (m == 3);
      tick(1);
      i_port_irq <= 1'b0;
      tick(3);
      chk(o_deep_sleep, 0);
      chk(o_serial_bus_en, m == 1);
    end
    // Clock enable low freezes state, so a wake is missed
    xfer(1'b1, SLEEP_ADDR, 32'h1);
    xfer(1'b1, PMC_ADDR, 32'h1);
    i_clk_en <= 1'b0;
    i_port_irq <= 1'b1;
    tick(3);
    chk(o_deep_sleep, 1);
    i_port_irq <= 1'b0;
    i_clk_en <= 1'b1;
    tick(2);
    chk(o_deep_sleep, 1);
    i_port_irq <= 1'b1;
    tick(1);
    i_port_irq <= 1'b0;
    tick(2);
    chk(o_deep_sleep, 0);
    xfer(1'b1, SLEEP_ADDR, 32'h4);
    tick(3);
    chk(o_hfrc_pd, 1);
    chk(o_xosc_pd, 0);
    i_clk_src_sel <= 1'b1;
    tick(4);
    chk(o_hfrc_pd, 0);
    chk(o_xosc_pd, 0);
    xfer(1'b0, SLEEP_ADDR, 32'h0);
    chk(rd & 32'h4, 0);
    i_cal_busy <= 1'b1;
    xfer(1'b1, SLEEP_ADDR, 32'h4);
    tick(3);
    chk(o_xosc_pd, 0);
    xfer(1'b0, SLEEP_ADDR, 32'h0);
    chk(rd & 32'h4, 0);
    i_cal_busy <= 1'b0;
    tick(4);
    chk(o_xosc_pd, 1);
    chk(o_hfrc_pd, 0);
    xfer(1'b0, SLEEP_ADDR, 32'h0);
    chk(rd & 32'h4, 32'h4);
    xfer(1'b1, PMC_ADDR, 32'h2);
    tick(6);
    chk(o_cpu_halt, 1);
    xfer(1'b0, PMC_ADDR, 32'h0);
    chk(rd, 0);
    i_reset_cause <= 2'h2;
    i_sys_rst <= 1'b1;
    tick(3);
    chk(o_cpu_halt, 0);
    chk(o_serial_bus_rst, 1);
    i_sys_rst <= 1'b0;
    tick(2);
    xfer(1'b0, SLEEP_ADDR, 32'h0);
    chk(rd & 32'h18, 32'h10);
    close_out();
  end
endmodule
`default_nettype wire
